// ===== shared/camac_map.vh
// constants for the arithmetic datapath: register indices, field positions,
// reset values, operation codes and divider timing.
// assumes inclusion by bare name from the design file.
`ifndef CAMAC_MAP_VH
`define CAMAC_MAP_VH

// ----------------------------------------------------------------------------
// register indices on the register port
// ----------------------------------------------------------------------------
`define CAMAC_REG_CONFIG      4'h0
`define CAMAC_REG_STATUS      4'h1
`define CAMAC_REG_TRAP_EN     4'h2
`define CAMAC_REG_ACCA_LO     4'h4
`define CAMAC_REG_ACCA_HI     4'h5
`define CAMAC_REG_ACCA_UP     4'h6
`define CAMAC_REG_ACCB_LO     4'h8
`define CAMAC_REG_ACCB_HI     4'h9
`define CAMAC_REG_ACCB_UP     4'hA

// ----------------------------------------------------------------------------
// core_config_reg fields and reset value
// ----------------------------------------------------------------------------
`define CAMAC_CFG_FRAC_INT    0
`define CAMAC_CFG_ROUND       1
`define CAMAC_CFG_SIGN_MODE   2
`define CAMAC_CFG_CLAMP_WIDTH 4
`define CAMAC_CFG_MEM_CLAMP   5
`define CAMAC_CFG_CLAMP_B     6
`define CAMAC_CFG_CLAMP_A     7
`define CAMAC_CFG_MASK        16'h00F7
`define CAMAC_CFG_RESET       16'h0020

// ----------------------------------------------------------------------------
// cpu_status_reg fields, trap enable fields
// ----------------------------------------------------------------------------
`define CAMAC_ST_BORROW       0
`define CAMAC_ST_NULL         1
`define CAMAC_ST_MSB          2
`define CAMAC_ST_ARITH        3
`define CAMAC_ST_HALF         4
`define CAMAC_ST_ANY_CLAMP    10
`define CAMAC_ST_ANY_GOVF     11
`define CAMAC_ST_B_CLAMP      12
`define CAMAC_ST_A_CLAMP      13
`define CAMAC_ST_B_GOVF       14
`define CAMAC_ST_A_GOVF       15
`define CAMAC_TE_A            0
`define CAMAC_TE_B            1

// ----------------------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------------------
`define CAMAC_OP_ADD          5'h00
`define CAMAC_OP_SUB          5'h01
`define CAMAC_OP_AND          5'h02
`define CAMAC_OP_IOR          5'h03
`define CAMAC_OP_XOR          5'h04
`define CAMAC_OP_SHL          5'h05
`define CAMAC_OP_LSR          5'h06
`define CAMAC_OP_ASR          5'h07
`define CAMAC_OP_INT_PRODUCT  5'h08
`define CAMAC_OP_DIVIDE       5'h09
`define CAMAC_OP_CLEAR        5'h0A
`define CAMAC_OP_SQ_DIST      5'h0B
`define CAMAC_OP_SQ_DIST_ACC  5'h0C
`define CAMAC_OP_MULT_ACCUM   5'h0D
`define CAMAC_OP_PREFETCH     5'h0E
`define CAMAC_OP_MULT_LOAD    5'h0F
`define CAMAC_OP_NEG_MULT     5'h10
`define CAMAC_OP_MULT_SUB     5'h11
`define CAMAC_OP_ACC_ADD      5'h12
`define CAMAC_OP_ACC_SUB      5'h13
`define CAMAC_OP_ACC_NEG      5'h14
`define CAMAC_OP_ACC_LOAD     5'h15
`define CAMAC_OP_ACC_ADD_SH   5'h16
`define CAMAC_OP_STORE_RND    5'h17

// ----------------------------------------------------------------------------
// divider timing and saturation values
// ----------------------------------------------------------------------------
`define CAMAC_DIV_STEPS       5'h10
`define CAMAC_MAX39           40'h7FFFFFFFFF
`define CAMAC_MIN39           40'h8000000000
`define CAMAC_MAX31           40'h007FFFFFFF
`define CAMAC_MIN31           40'hFF80000000
`define CAMAC_RND_HALF        40'h0000008000

`endif

// ===== rtl/camac_core.v
// arithmetic datapath: 16-bit integer unit, shared 17x17 multiplier,
// iterative divider and the 40-bit accumulator engine with saturation.
// assumes the instruction decoder supplies operands from the working registers
// or memory and writes back res_lo/res_hi; one operation at a time.
//
// Strobed register access and the placing of the registers were left to the implementer.
`include "camac_map.vh"
`timescale 1ns/1ns
`default_nettype none

module camac_core (
  input  wire        clock,
  input  wire        rst,
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire        op_byte,
  input  wire        op_a_signed,
  input  wire        op_b_signed,
  input  wire        op_literal,
  input  wire        op_long,
  input  wire        op_acc_b,
  input  wire [4:0]  op_shift,
  input  wire [15:0] op_a,
  input  wire [15:0] op_b,
  input  wire [15:0] op_hi,
  output wire        op_ready,
  output reg         res_valid,
  output reg  [15:0] res_lo,
  output reg  [15:0] res_hi,
  output reg  [15:0] quotient_reg,
  output reg  [15:0] remainder_reg,
  output wire [15:0] cpu_status_reg,
  output reg         arith_trap,
  output reg  [39:0] acc_a,
  output reg  [39:0] acc_b,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata
);

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // signed 17x17 multiply, keeps the 33 meaningful bits
  function [32:0] mul17;
    input [16:0] x;
    input [16:0] y;
    reg   [33:0] p;
    begin
      p = $signed(x) * $signed(y);
      mul17 = p[32:0];
    end
  endfunction

  // barrel shift: positive count shifts right arithmetically, negative left
  function [39:0] barrel40;
    input [39:0] v;
    input [4:0]  sh;
    begin
      if (sh[4]) begin
        barrel40 = v << (5'h00 - sh);
      end else begin
        barrel40 = $signed(v) >>> sh;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [15:0] core_config_reg;
  reg  [1:0]  trap_en;
  reg         borrow_flag;
  reg         all_null_flag;
  reg         msb_flag;
  reg         arith_flag;
  reg         half_borrow_flag;
  reg         acc_a_guard_ovf;
  reg         acc_b_guard_ovf;
  reg         acc_a_clamped;
  reg         acc_b_clamped;
  reg         div_run;
  reg  [4:0]  div_cnt;
  reg  [15:0] div_rem;
  reg  [15:0] div_dq;
  reg  [15:0] div_dvs;
  reg         div_qneg;
  reg         div_rneg;

  // --------------------------------------------------------------------------
  // combinational datapath signals
  // --------------------------------------------------------------------------
  reg  [15:0] alu_bt;
  reg         alu_cin;
  reg  [16:0] sum16;
  reg  [8:0]  sum8;
  reg  [4:0]  sum4;
  reg  [15:0] alu_r;
  reg         alu_c;
  reg         alu_ov;
  reg         alu_dc;
  reg         alu_arith;
  reg         alu_en;
  reg  [15:0] sq_diff;
  reg  [16:0] mx;
  reg  [16:0] my;
  reg  [32:0] prod;
  reg  [32:0] scaled;
  reg  [39:0] prod40;
  reg  [39:0] acc_src;
  reg  [39:0] acc_oth;
  reg  [39:0] load40;
  reg         add_en;
  reg  [39:0] add_x;
  reg  [39:0] add_y;
  reg         add_sub;
  reg  [39:0] ytr;
  reg  [39:0] sum40;
  reg         cat_ovf;
  reg         true_neg;
  reg         guard_mix;
  reg         mix31;
  reg         sat_en;
  reg         sat_hit;
  reg  [39:0] next_acc;
  reg  [39:0] rnd40;
  reg  [15:0] store_word;
  reg  [16:0] div_t;
  reg  [15:0] next_q;
  reg  [15:0] next_r;
  reg  [31:0] dvd_mag;
  reg  [15:0] dvs_mag;
  reg         dvd_neg;
  reg         dvs_neg;

  wire op_take = op_valid & ~div_run;
  wire frac_mode = ~core_config_reg[`CAMAC_CFG_FRAC_INT];
  wire dsp_signed = ~core_config_reg[`CAMAC_CFG_SIGN_MODE];

  // no overlap
  // new work is refused while the divider iterates
  assign op_ready = ~div_run;

  assign cpu_status_reg = {acc_a_guard_ovf, acc_b_guard_ovf, acc_a_clamped, acc_b_clamped,
                           acc_a_guard_ovf | acc_b_guard_ovf,
                           acc_a_clamped | acc_b_clamped, 5'h00,
                           half_borrow_flag, arith_flag, msb_flag, all_null_flag,
                           borrow_flag};

  // --------------------------------------------------------------------------
  // integer unit
  // --------------------------------------------------------------------------
  // add and subtract share one adder; logic and shifts beside it
  always @* begin
    alu_bt    = op_b;
    alu_cin   = 1'b0;
    alu_r     = 16'h0000;
    alu_arith = 1'b0;
    alu_en    = 1'b1;
    // inverted borrow
    // subtract adds the complement with carry-in set, so carry means no borrow
    if (op_code == `CAMAC_OP_SUB) begin
      alu_bt  = ~op_b;
      alu_cin = 1'b1;
    end
    sum16 = {1'b0, op_a} + {1'b0, alu_bt} + {16'h0000, alu_cin};
    sum8  = {1'b0, op_a[7:0]} + {1'b0, alu_bt[7:0]} + {8'h00, alu_cin};
    sum4  = {1'b0, op_a[3:0]} + {1'b0, alu_bt[3:0]} + {4'h0, alu_cin};
    case (op_code)
      `CAMAC_OP_ADD, `CAMAC_OP_SUB: begin
        alu_r     = op_byte ? {op_a[15:8], sum8[7:0]} : sum16[15:0];
        alu_arith = 1'b1;
      end
      `CAMAC_OP_AND: alu_r = op_a & op_b;
      `CAMAC_OP_IOR: alu_r = op_a | op_b;
      `CAMAC_OP_XOR: alu_r = op_a ^ op_b;
      `CAMAC_OP_SHL: alu_r = op_a << op_b[3:0];
      `CAMAC_OP_LSR: alu_r = op_a >> op_b[3:0];
      `CAMAC_OP_ASR: alu_r = $signed(op_a) >>> op_b[3:0];
      default: alu_en = 1'b0;
    endcase
    // byte or word
    // byte results keep the upper byte of the first operand
    if (op_byte & (op_code != `CAMAC_OP_ADD) & (op_code != `CAMAC_OP_SUB)) begin
      alu_r = {op_a[15:8], alu_r[7:0]};
    end
    alu_c  = op_byte ? sum8[8] : sum16[16];
    alu_dc = op_byte ? sum4[4] : sum8[8];
    alu_ov = op_byte ? ((op_a[7] == alu_bt[7]) & (sum8[7] != op_a[7]))
                     : ((op_a[15] == alu_bt[15]) & (sum16[15] != op_a[15]));
  end

  // --------------------------------------------------------------------------
  // shared multiplier, scaler, accumulator adder and saturation
  // --------------------------------------------------------------------------
  always @* begin
    sq_diff = op_a - op_b;
    if (op_code == `CAMAC_OP_INT_PRODUCT) begin
      if (op_byte) begin
        mx = {9'h000, op_a[7:0]};
        my = {9'h000, op_b[7:0]};
      end else begin
        mx = {op_a_signed & op_a[15], op_a};
        my = op_literal ? {12'h000, op_b[4:0]} : {op_b_signed & op_b[15], op_b};
      end
    end else if ((op_code == `CAMAC_OP_SQ_DIST) | (op_code == `CAMAC_OP_SQ_DIST_ACC)) begin
      mx = {sq_diff[15], sq_diff};
      my = {sq_diff[15], sq_diff};
    end else begin
      mx = {dsp_signed & op_a[15], op_a};
      my = {dsp_signed & op_b[15], op_b};
    end
    prod = mul17(mx, my);
    scaled = frac_mode ? {prod[31:0], 1'b0} : prod;
    prod40 = {{7{scaled[32]}}, scaled};
    acc_src = op_acc_b ? acc_b : acc_a;
    acc_oth = op_acc_b ? acc_a : acc_b;
    load40  = barrel40({{8{op_a[15]}}, op_a, 16'h0000}, op_shift);
    add_en  = 1'b1;
    add_x   = 40'h0000000000;
    add_y   = 40'h0000000000;
    add_sub = 1'b0;
    case (op_code)
      `CAMAC_OP_CLEAR: add_sub = 1'b0;
      `CAMAC_OP_SQ_DIST: add_y = prod40;
      `CAMAC_OP_SQ_DIST_ACC, `CAMAC_OP_MULT_ACCUM: begin
        add_x = acc_src;
        add_y = prod40;
      end
      `CAMAC_OP_MULT_LOAD: add_y = prod40;
      `CAMAC_OP_NEG_MULT: begin
        add_y   = prod40;
        add_sub = 1'b1;
      end
      `CAMAC_OP_MULT_SUB: begin
        add_x   = acc_src;
        add_y   = prod40;
        add_sub = 1'b1;
      end
      `CAMAC_OP_ACC_ADD: begin
        add_x = acc_src;
        add_y = acc_oth;
      end
      `CAMAC_OP_ACC_SUB: begin
        add_x   = acc_src;
        add_y   = acc_oth;
        add_sub = 1'b1;
      end
      `CAMAC_OP_ACC_NEG: begin
        add_y   = acc_src;
        add_sub = 1'b1;
      end
      `CAMAC_OP_ACC_LOAD: add_y = load40;
      `CAMAC_OP_ACC_ADD_SH: begin
        add_x = acc_src;
        add_y = load40;
      end
      default: add_en = 1'b0;
    endcase
    ytr   = add_sub ? ~add_y : add_y;
    sum40 = add_x + ytr + {39'h0000000000, add_sub};
    cat_ovf   = (add_x[39] == ytr[39]) & (sum40[39] != add_x[39]);
    true_neg  = cat_ovf ? add_x[39] : sum40[39];
    guard_mix = (sum40[39:32] != 8'h00) & (sum40[39:32] != 8'hFF);
    mix31     = (sum40[39:31] != 9'h000) & (sum40[39:31] != 9'h1FF);
    sat_en = op_acc_b ? core_config_reg[`CAMAC_CFG_CLAMP_B]
                      : core_config_reg[`CAMAC_CFG_CLAMP_A];
    sat_hit  = 1'b0;
    next_acc = sum40;
    if (sat_en & core_config_reg[`CAMAC_CFG_CLAMP_WIDTH] & cat_ovf) begin
      sat_hit  = 1'b1;
      next_acc = true_neg ? `CAMAC_MIN39 : `CAMAC_MAX39;
    end else if (sat_en & ~core_config_reg[`CAMAC_CFG_CLAMP_WIDTH] & (cat_ovf | mix31)) begin
      sat_hit  = 1'b1;
      next_acc = true_neg ? `CAMAC_MIN31 : `CAMAC_MAX31;
    end
    // rounding style
    // convergent rounding leaves an exact half on an even value alone
    if (core_config_reg[`CAMAC_CFG_ROUND] & (acc_src[16:0] == 17'h08000)) begin
      rnd40 = acc_src;
    end else begin
      rnd40 = acc_src + `CAMAC_RND_HALF;
    end
    store_word = rnd40[31:16];
    if (core_config_reg[`CAMAC_CFG_MEM_CLAMP] & (rnd40[39:31] != 9'h000)
        & (rnd40[39:31] != 9'h1FF)) begin
      store_word = rnd40[39] ? 16'h8000 : 16'h7FFF;
    end
  end

  // --------------------------------------------------------------------------
  // divider operand preparation and one restoring step
  // --------------------------------------------------------------------------
  always @* begin
    // long dividend
    // upper half comes from the odd register of the pair on op_hi
    dvd_neg = op_a_signed & (op_long ? op_hi[15] : op_a[15]);
    dvs_neg = op_a_signed & op_b[15];
    dvd_mag = op_long ? {op_hi, op_a} : {{16{dvd_neg}}, op_a};
    if (dvd_neg) begin
      dvd_mag = 32'h00000000 - dvd_mag;
    end
    dvs_mag = dvs_neg ? (16'h0000 - op_b) : op_b;
    div_t  = {div_rem, div_dq[15]} - {1'b0, div_dvs};
    next_q = {div_dq[14:0], ~div_t[16]};
    next_r = div_t[16] ? {div_rem[14:0], div_dq[15]} : div_t[15:0];
  end

  // --------------------------------------------------------------------------
  // registers: operation execution and register port
  // --------------------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      core_config_reg  <= `CAMAC_CFG_RESET;
      trap_en          <= 2'b00;
      borrow_flag      <= 1'b0;
      all_null_flag    <= 1'b0;
      msb_flag         <= 1'b0;
      arith_flag       <= 1'b0;
      half_borrow_flag <= 1'b0;
      acc_a_guard_ovf  <= 1'b0;
      acc_b_guard_ovf  <= 1'b0;
      acc_a_clamped    <= 1'b0;
      acc_b_clamped    <= 1'b0;
      acc_a            <= 40'h0000000000;
      acc_b            <= 40'h0000000000;
      res_valid        <= 1'b0;
      res_lo           <= 16'h0000;
      res_hi           <= 16'h0000;
      quotient_reg     <= 16'h0000;
      remainder_reg    <= 16'h0000;
      arith_trap       <= 1'b0;
      reg_rdata        <= 16'h0000;
      div_run          <= 1'b0;
      div_cnt          <= 5'h00;
      div_rem          <= 16'h0000;
      div_dq           <= 16'h0000;
      div_dvs          <= 16'h0000;
      div_qneg         <= 1'b0;
      div_rneg         <= 1'b0;
    end else begin
      res_valid  <= 1'b0;
      arith_trap <= 1'b0;
      // register reads answer one cycle later
      if (reg_rd) begin
        case (reg_addr)
          `CAMAC_REG_CONFIG:  reg_rdata <= core_config_reg;
          `CAMAC_REG_STATUS:  reg_rdata <= cpu_status_reg;
          `CAMAC_REG_TRAP_EN: reg_rdata <= {14'h0000, trap_en};
          `CAMAC_REG_ACCA_LO: reg_rdata <= acc_a[15:0];
          `CAMAC_REG_ACCA_HI: reg_rdata <= acc_a[31:16];
          `CAMAC_REG_ACCA_UP: reg_rdata <= {8'h00, acc_a[39:32]};
          `CAMAC_REG_ACCB_LO: reg_rdata <= acc_b[15:0];
          `CAMAC_REG_ACCB_HI: reg_rdata <= acc_b[31:16];
          `CAMAC_REG_ACCB_UP: reg_rdata <= {8'h00, acc_b[39:32]};
          default:            reg_rdata <= 16'h0000;
        endcase
      end
      // software writes; hardware updates below take priority
      if (reg_wr) begin
        case (reg_addr)
          `CAMAC_REG_CONFIG:  core_config_reg <= reg_wdata & `CAMAC_CFG_MASK;
          `CAMAC_REG_TRAP_EN: trap_en <= reg_wdata[1:0];
          `CAMAC_REG_STATUS: begin
            borrow_flag      <= reg_wdata[`CAMAC_ST_BORROW];
            all_null_flag    <= reg_wdata[`CAMAC_ST_NULL];
            msb_flag         <= reg_wdata[`CAMAC_ST_MSB];
            arith_flag       <= reg_wdata[`CAMAC_ST_ARITH];
            half_borrow_flag <= reg_wdata[`CAMAC_ST_HALF];
            acc_a_clamped    <= acc_a_clamped & reg_wdata[`CAMAC_ST_A_CLAMP];
            acc_b_clamped    <= acc_b_clamped & reg_wdata[`CAMAC_ST_B_CLAMP];
          end
          default: ;
        endcase
      end
      if (op_take & alu_en) begin
        res_lo        <= alu_r;
        res_hi        <= 16'h0000;
        res_valid     <= 1'b1;
        all_null_flag <= op_byte ? (alu_r[7:0] == 8'h00) : (alu_r == 16'h0000);
        msb_flag      <= op_byte ? alu_r[7] : alu_r[15];
        if (alu_arith) begin
          borrow_flag      <= alu_c;
          arith_flag       <= alu_ov;
          half_borrow_flag <= alu_dc;
        end
      end
      if (op_take & (op_code == `CAMAC_OP_INT_PRODUCT)) begin
        res_lo    <= prod[15:0];
        res_hi    <= op_byte ? 16'h0000 : prod[31:16];
        res_valid <= 1'b1;
      end
      if (op_take & add_en) begin
        res_valid <= 1'b1;
        res_lo    <= sq_diff;
        res_hi    <= 16'h0000;
        if (op_acc_b) begin
          acc_b           <= next_acc;
          acc_b_guard_ovf <= guard_mix;
          // set wins over a software clear; without a clamp the clear stands
          if (sat_hit) begin
            acc_b_clamped <= 1'b1;
          end
          arith_trap      <= guard_mix & trap_en[`CAMAC_TE_B];
        end else begin
          acc_a           <= next_acc;
          acc_a_guard_ovf <= guard_mix;
          if (sat_hit) begin
            acc_a_clamped <= 1'b1;
          end
          arith_trap      <= guard_mix & trap_en[`CAMAC_TE_A];
        end
      end
      if (op_take & ((op_code == `CAMAC_OP_PREFETCH) | (op_code == `CAMAC_OP_STORE_RND))) begin
        res_lo    <= store_word;
        res_hi    <= 16'h0000;
        res_valid <= 1'b1;
      end
      if (op_take & (op_code == `CAMAC_OP_DIVIDE)) begin
        div_run  <= 1'b1;
        div_cnt  <= 5'h00;
        div_rem  <= dvd_mag[31:16];
        div_dq   <= dvd_mag[15:0];
        div_dvs  <= dvs_mag;
        div_qneg <= dvd_neg ^ dvs_neg;
        div_rneg <= dvd_neg;
      end
      if (div_run) begin
        div_rem <= next_r;
        div_dq  <= next_q;
        div_cnt <= div_cnt + 5'h01;
        if (div_cnt == (`CAMAC_DIV_STEPS - 5'h01)) begin
          div_run       <= 1'b0;
          quotient_reg  <= div_qneg ? (16'h0000 - next_q) : next_q;
          remainder_reg <= div_rneg ? (16'h0000 - next_r) : next_r;
          res_lo        <= div_qneg ? (16'h0000 - next_q) : next_q;
          res_hi        <= div_rneg ? (16'h0000 - next_r) : next_r;
          res_valid     <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/camac_chk_asserts.sv
// checker for the arithmetic core: op timing, status ORs, trap, reads.
// assumes one clock, synchronous active-high reset, bound to camac_core.
`include "camac_map.vh"
`timescale 1ns/1ns
`default_nettype none
module camac_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire logic [4:0]  op_code,
  input wire logic        op_ready,
  input wire logic        res_valid,
  input wire logic [15:0] cpu_status_reg,
  input wire logic        arith_trap,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // divide taken on this edge
  wire div_go = op_valid && op_ready && op_code == `CAMAC_OP_DIVIDE;
  a_div_busy: assert property (div_go |=> !op_ready [*8]) else $error("ready during divide");
  a_div_answer: assert property (div_go |-> ##17 res_valid) else $error("divide late");
  a_div_quiet: assert property (div_go |=> !res_valid [*8]) else $error("divide early");
  a_alu_answer: assert property (op_valid && op_ready && op_code <= `CAMAC_OP_ASR
    |=> res_valid) else $error("alu result late");
  a_res_pulse: assert property (res_valid |=> !res_valid || $past(op_valid && op_ready))
    else $error("result not a pulse");
  a_any_guard: assert property (cpu_status_reg[11] == (cpu_status_reg[15] | cpu_status_reg[14]))
    else $error("guard or wrong");
  a_any_clamp: assert property (cpu_status_reg[10] == (cpu_status_reg[13] | cpu_status_reg[12]))
    else $error("clamp or wrong");
  a_trap_cause: assert property (arith_trap |-> cpu_status_reg[15] | cpu_status_reg[14])
    else $error("trap without guard flag");
  a_unmapped_read: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  c_div: cover property (div_go);
  c_trap: cover property (arith_trap);
  c_clamp: cover property (cpu_status_reg[13]);
endmodule
bind camac_core camac_chk u_chk (.clock(clock), .rst(rst), .op_valid(op_valid),
  .op_code(op_code), .op_ready(op_ready), .res_valid(res_valid),
  .cpu_status_reg(cpu_status_reg), .arith_trap(arith_trap), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata));
`default_nettype wire

// ===== test/camac_wreg.sv
// model of the working register array feeding the upper dividend half.
// assumes writes from the bench, pair index selects an aligned pair.
`timescale 1ns/1ns
`default_nettype none
module camac_wreg (
  input  wire logic        clock,
  input  wire logic        wr,
  input  wire logic [3:0]  idx,
  input  wire logic [15:0] wd,
  input  wire logic [2:0]  pair,
  output logic      [15:0] hi
);
  logic [15:0] w [16];
  // clear the array at start
  initial for (int i = 0; i < 16; i++) w[i] = 16'h0000;
  // register write
  always @(posedge clock) begin
    if (wr) w[idx] <= wd;
  end
  assign hi = w[{pair, 1'b1}];
endmodule
`default_nettype wire

// ===== test/camac_core_tb.sv
// self-checking bench for the arithmetic core.
// assumes camac_core, camac_wreg and the checker are compiled before it.
`include "camac_map.vh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module camac_core_tb;
  logic clock, rst, op_valid, op_byte, op_a_signed, op_b_signed, op_long;
  logic [4:0] op_code, op_shift;
  logic [15:0] op_a, op_b, op_hi, res_lo, res_hi, quotient_reg, remainder_reg;
  logic [15:0] cpu_status_reg, reg_wdata, reg_rdata, pwd;
  logic op_ready, res_valid, arith_trap, reg_wr, reg_rd, pw, trap, op_literal, op_acc_b;
  logic [39:0] acc_a, acc_b;
  logic [3:0] reg_addr, pidx;
  int n_fail, samples_checked, cyc;
  // rows: code, long/byte/a-signed/b-signed, a, b, lo, hi
  logic [72:0] rows [7] = '{
    {`CAMAC_OP_ADD, 4'h0, 16'h0001, 16'h0002, 16'h0003, 16'h0000},
    {`CAMAC_OP_SUB, 4'h0, 16'h0005, 16'h0003, 16'h0002, 16'h0000},
    {`CAMAC_OP_AND, 4'h0, 16'hF0F0, 16'hFF00, 16'hF000, 16'h0000},
    {`CAMAC_OP_INT_PRODUCT, 4'h0, 16'hFFFF, 16'hFFFF, 16'h0001, 16'hFFFE},
    {`CAMAC_OP_INT_PRODUCT, 4'h3, 16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000},
    {`CAMAC_OP_INT_PRODUCT, 4'h1, 16'hFFFF, 16'hFFFF, 16'h0001, 16'hFFFF},
    {`CAMAC_OP_INT_PRODUCT, 4'h4, 16'h00FF, 16'h00FF, 16'hFE01, 16'h0000}};
  camac_wreg u_wreg (.clock(clock), .wr(pw), .idx(pidx), .wd(pwd), .pair(3'h1),
    .hi(op_hi));
  camac_core DUT (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_byte(op_byte), .op_a_signed(op_a_signed), .op_b_signed(op_b_signed),
    .op_literal(op_literal), .op_long(op_long), .op_acc_b(op_acc_b), .op_shift(op_shift),
    .op_a(op_a), .op_b(op_b), .op_hi(op_hi), .op_ready(op_ready),
    .res_valid(res_valid), .res_lo(res_lo), .res_hi(res_hi),
    .quotient_reg(quotient_reg), .remainder_reg(remainder_reg),
    .cpu_status_reg(cpu_status_reg), .arith_trap(arith_trap), .acc_a(acc_a),
    .acc_b(acc_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // clock generator
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  // verdict and end of run
  task print_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one operation, waits for its result pulse
  task automatic op(input logic [4:0] c, input logic [3:0] f, input logic [15:0] a, b);
    @(posedge clock);
    op_valid <= 1;
    op_code <= c;
    {op_long, op_byte, op_a_signed, op_b_signed} <= f;
    op_a <= a;
    op_b <= b;
    @(posedge clock);
    op_valid <= 0;
    #1;
    for (cyc = 0; res_valid !== 1'b1 && cyc < 40; cyc++) begin @(posedge clock); #1; end
    if (res_valid !== 1'b1) begin n_fail++; print_verdict; end
    else trap = arith_trap;
  endtask
  // register port access
  task automatic rg(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
  endtask
  // main sequence
  initial begin
    {rst, op_valid, op_byte, op_a_signed, op_b_signed, op_long, reg_wr, reg_rd, pw} = 9'h100;
    {op_code, op_a, op_b, reg_addr, reg_wdata, pidx, pwd, op_literal, op_acc_b, op_shift} = 0;
    repeat (3) @(posedge clock);
    rst <= 0;
    rg(0, 4'h0, 0); `CHK("config", 16'h0020, reg_rdata)
    rg(0, 4'h3, 0); `CHK("unmapped", 16'h0000, reg_rdata)
    foreach (rows[i]) begin
      op(rows[i][72:68], rows[i][67:64], rows[i][63:48], rows[i][47:32]);
      `CHK("res_lo", rows[i][31:16], res_lo)
      if (rows[i][72:68] == `CAMAC_OP_INT_PRODUCT) `CHK("res_hi", rows[i][15:0], res_hi)
    end
    op(`CAMAC_OP_SUB, 0, 16'h0003, 16'h0005); `CHK("sub_flags", 5'h04, cpu_status_reg[4:0])
    rg(1, 4'h0, 16'h0000);
    rg(1, 4'h2, 16'h0001);
    op(`CAMAC_OP_MULT_LOAD, 0, 16'h4000, 16'h4000); `CHK("frac", 40'h0020000000, acc_a)
    op(`CAMAC_OP_NEG_MULT, 0, 16'h4000, 16'h4000); `CHK("neg", 40'hFFE0000000, acc_a)
    op(`CAMAC_OP_MULT_LOAD, 0, 16'h8000, 16'h8000);
    op(`CAMAC_OP_MULT_ACCUM, 0, 16'h8000, 16'h8000); `CHK("mac", 40'h0100000000, acc_a)
    `CHK("guard", 1'b1, cpu_status_reg[15])
    `CHK("trap", 1'b1, trap)
    rg(1, 4'h0, 16'h0080);
    op(`CAMAC_OP_MULT_LOAD, 0, 16'h8000, 16'h8000); `CHK("sat", 40'h007FFFFFFF, acc_a)
    `CHK("clamped", 1'b1, cpu_status_reg[13])
    op(`CAMAC_OP_ACC_NEG, 0, 0, 0); `CHK("acc_neg", 40'hFF80000001, acc_a)
    op(`CAMAC_OP_CLEAR, 0, 0, 0); `CHK("clear", 40'h0000000000, acc_a)
    rg(1, 4'h1, 16'h0000); `CHK("clamp_clr", 1'b0, cpu_status_reg[13])
    @(posedge clock);
    op_literal <= 1;
    op(`CAMAC_OP_INT_PRODUCT, 4'h2, 16'hFFFD, 16'hFFE5); `CHK("lit", 16'hFFF1, res_lo)
    `CHK("lit_hi", 16'hFFFF, res_hi)
    @(posedge clock);
    {op_literal, op_acc_b, op_shift} <= {2'b01, 5'h01};
    op(`CAMAC_OP_ACC_LOAD, 0, 16'h4000, 0); `CHK("load_r", 40'h0020000000, acc_b)
    `CHK("acc_a_kept", 40'h0000000000, acc_a)
    @(posedge clock);
    op_shift <= 5'h1F;
    op(`CAMAC_OP_ACC_LOAD, 0, 16'h4000, 0); `CHK("load_l", 40'h0080000000, acc_b)
    op(`CAMAC_OP_STORE_RND, 0, 0, 0); `CHK("store", 16'h8000, res_lo)
    @(posedge clock);
    {op_acc_b, op_shift} <= 6'h00;
    @(posedge clock);
    {pw, pidx, pwd} <= {1'b1, 4'h3, 16'h0001};
    @(posedge clock);
    pw <= 0;
    op(`CAMAC_OP_DIVIDE, 4'h8, 16'h0000, 16'h0002); `CHK("quot", 16'h8000, quotient_reg)
    `CHK("rem", 16'h0000, remainder_reg)
    `CHK("cycles", 16, cyc)
    op(`CAMAC_OP_DIVIDE, 4'h2, 16'hFFF9, 16'h0002); `CHK("squot", 16'hFFFD, quotient_reg)
    `CHK("srem", 16'hFFFF, remainder_reg)
    `CHK("scycles", 16, cyc)
    @(posedge clock);
    rst <= 1;
    @(posedge clock);
    rst <= 0;
    rg(0, 4'h0, 0); `CHK("rst_config", 16'h0020, reg_rdata)
    `CHK("rst_acc_b", 40'h0000000000, acc_b)
    `CHK("rst_quot", 16'h0000, quotient_reg)
    print_verdict;
  end
endmodule
`default_nettype wire
